// file: hdl/eeprw_core.v
// eeprw_core.v: two-wire EEPROM slave with write polling, ECC groups and reads
// assumes scl and sda arrive asynchronously; sda is open drain, the pad is outside
`timescale 1ns/1ns
`default_nettype none
`include "eeprw_map.vh"
module eeprw_core #(
	parameter AW        = `EEPRW_ADDR_BITS,
	parameter DEPTH     = `EEPRW_FIFO_DEPTH,
	parameter TW_CYCLES = `EEPRW_TW_CYCLES
) (
	// clock and reset
	input  wire clock_i,
	input  wire rst_i,
	// two-wire bus pins
	input  wire scl_i,
	input  wire sda_i,
	output wire sda_o,
	output reg  sda_oe_n_o,
	// status
	output reg  busy_o
);
	localparam ST_IDLE = 3'h0;
	localparam ST_SEL  = 3'h1;
	localparam ST_AHI  = 3'h2;
	localparam ST_ALO  = 3'h3;
	localparam ST_WDAT = 3'h4;
	localparam ST_RDAT = 3'h5;
	localparam FW      = AW + 8;
	localparam [31:0] TW_LAST = TW_CYCLES - 1;

	// array of code-protected four-byte groups, check bits on top
	reg [37:0] mem [0:(1 << (AW - 2)) - 1];

	reg          scl_s1, scl_s2, scl_d;
	reg          sda_s1, sda_s2, sda_d;
	reg [2:0]    state;
	reg [3:0]    bit_cnt;
	reg [7:0]    shreg;
	reg          feat;
	reg          mack;
	reg          last_ack;
	reg [1:0]    wr_cnt;
	reg [1:0]    sel_hi;
	reg [7:0]    ahi;
	reg [7:0]    feat_loc;
	reg [AW-1:0] addr_cnt;
	reg [7:0]    cda;
	reg [7:0]    cda_new;
	reg          cda_pend;
	reg [31:0]   tw_cnt;

	wire          scl_rise, scl_fall, bus_start, bus_stop;
	wire          sel_ok, ack_now, commit, fifo_clr;
	wire          push_valid, in_ready, out_valid;
	wire [FW-1:0] out_data;
	wire [AW-3:0] grp;
	wire [37:0]   grp_word;
	wire [31:0]   grp_cor;
	wire [31:0]   merged;
	wire [5:0]    merged_chk;
	wire [7:0]    rd_byte;
	wire [17:0]   full_addr;

	// pick one byte of a group by its low address bits
	function [7:0] get_byte;
		input [31:0] w;
		input [1:0]  s;
		begin
			get_byte = w[8*s +: 8];
		end
	endfunction

	// select code match: memory or feature type, chip enable against stored bit
	function sel_match;
		input [7:0] b;
		input       c2;
		begin
			sel_match = ((b[7:4] == `EEPRW_DEVTYPE_MEM) || (b[7:4] == `EEPRW_DEVTYPE_FEAT))
				&& (b[`EEPRW_SEL_CE_BIT] == c2);
		end
	endfunction

	// open drain: only the enable moves, the level is always low
	assign sda_o = 1'b0;

	// two-flop synchronisers, third flop only for edge finding
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d  <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
		end
	end

	// bus events seen on the synchronised lines
	assign scl_rise  = scl_s2 & ~scl_d;
	assign scl_fall  = ~scl_s2 & scl_d;
	assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

	// a busy device refuses any select code; the bit compared is the live one
	assign sel_ok = sel_match(shreg, cda[`EEPRW_CDA_C2_BIT]) && !busy_o;

	// data byte into the buffer; a full buffer turns into a refused byte
	assign push_valid = scl_fall && (state == ST_WDAT) && (bit_cnt == 4'h8) && !feat && !busy_o;
	assign ack_now    = feat ? 1'b1 : in_ready;

	// stop right after a data acknowledge, i.e. one clock into slot ten
	assign commit = bus_stop && (state == ST_WDAT) && (bit_cnt == 4'h1) && last_ack
		&& (feat ? ((wr_cnt == 2'h1) && (feat_loc == `EEPRW_CDA_ADDR)) : out_valid);

	// any other stop or start outside the write cycle throws the latched bytes away
	assign fifo_clr = (bus_start | bus_stop) & ~commit & ~busy_o;

	// one group read serves both the output path and the group rewrite
	assign grp      = busy_o ? out_data[AW+7:10] : addr_cnt[AW-1:2];
	assign grp_word = mem[grp];
	assign rd_byte  = feat ? ((feat_loc == `EEPRW_CDA_ADDR) ? cda : `EEPRW_FEAT_IDLE)
		: get_byte(grp_cor, addr_cnt[1:0]);
	assign full_addr = {sel_hi, ahi, shreg};

	// replace the addressed byte, keep the three neighbours of the group
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_merge
			assign merged[8*g +: 8] = (out_data[9:8] == g) ? out_data[7:0]
				: grp_cor[8*g +: 8];
		end
	endgenerate

	// correction on every read, fresh check bits on every rewrite
	eeprw_ecc u_ecc (
		.wdat_i (merged),
		.wchk_o (merged_chk),
		.rdat_i (grp_word[31:0]),
		.rchk_i (grp_word[37:32]),
		.rcor_o (grp_cor)
	);

	// write buffer: address and data, drained only during the write cycle
	eeprw_fifo #(
		.W     (FW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.clr_i       (fifo_clr),
		.in_valid_i  (push_valid),
		.in_ready_o  (in_ready),
		.in_data_i   ({addr_cnt, shreg}),
		.out_valid_o (out_valid),
		.out_ready_i (busy_o),
		.out_data_o  (out_data)
	);

	// group rewrite, one buffered byte per clock while busy
	always @(posedge clock_i) begin
		if (busy_o && out_valid)
			mem[grp] <= {merged_chk, merged};
	end

	// internal write cycle: timed, drains the buffer, then applies a new chip enable after a feature write
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o   <= 1'b0;
			tw_cnt   <= 32'h0;
			cda      <= `EEPRW_CDA_RESET;
			cda_pend <= 1'b0;
		end else if (commit) begin
			busy_o   <= 1'b1;
			tw_cnt   <= 32'h0;
			cda_pend <= feat; // latched: polling selects rewrite feat during the cycle
		end else if (busy_o) begin
			if (tw_cnt >= TW_LAST && !out_valid) begin
				busy_o   <= 1'b0;
				cda_pend <= 1'b0;
				if (cda_pend)
					cda <= cda_new;
			end else if (tw_cnt < TW_LAST) begin
				tw_cnt <= tw_cnt + 32'h1;
			end
		end
	end

	// protocol engine: bit counting, acknowledges, byte output, counter moves
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state      <= ST_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			sda_oe_n_o <= 1'b1;
			feat       <= 1'b0;
			mack       <= 1'b0;
			last_ack   <= 1'b0;
			wr_cnt     <= 2'h0;
			sel_hi     <= 2'h0;
			ahi        <= 8'h00;
			feat_loc   <= 8'h00;
			addr_cnt   <= {AW{1'b0}};
			cda_new    <= `EEPRW_CDA_RESET;
		end else if (bus_start) begin
			state      <= ST_SEL;
			bit_cnt    <= 4'h0;
			sda_oe_n_o <= 1'b1;
		end else if (bus_stop) begin
			state      <= ST_IDLE;
			sda_oe_n_o <= 1'b1;
		end else if (scl_rise && state != ST_IDLE) begin
			bit_cnt <= bit_cnt + 4'h1;
			// the acknowledge slot is not shifted in; the direction bit is read after it
			if (state != ST_RDAT && bit_cnt != 4'h8)
				shreg <= {shreg[6:0], sda_s2};
			if (state == ST_RDAT && bit_cnt == 4'h8) begin
				mack <= ~sda_s2;
				if (!feat)
					addr_cnt <= addr_cnt + {{(AW-1){1'b0}}, 1'b1};
			end
		end else if (scl_fall && state != ST_IDLE) begin
			if (bit_cnt == 4'h8) begin
				// ninth slot: drive or withhold the acknowledge
				case (state)
					ST_SEL: begin
						sda_oe_n_o <= ~sel_ok;
						feat       <= shreg[7:4] == `EEPRW_DEVTYPE_FEAT;
						sel_hi     <= shreg[2:1];
					end
					ST_AHI: begin
						sda_oe_n_o <= 1'b0;
						ahi        <= shreg;
					end
					ST_ALO: begin
						sda_oe_n_o <= 1'b0;
						addr_cnt   <= full_addr[AW-1:0];
						feat_loc   <= shreg;
						wr_cnt     <= 2'h0;
						last_ack   <= 1'b0; // no stale acknowledge from an older write
					end
					ST_WDAT: begin
						sda_oe_n_o <= ~ack_now;
						last_ack   <= ack_now;
						if (wr_cnt != 2'h3)
							wr_cnt <= wr_cnt + 2'h1;
						if (feat)
							cda_new <= shreg;
						else if (ack_now)
							addr_cnt[7:0] <= addr_cnt[7:0] + 8'h01;
					end
					default: begin
						sda_oe_n_o <= 1'b1; // release for the controller's acknowledge
					end
				endcase
			end else if (bit_cnt == 4'h9) begin
				// end of the acknowledge slot: next byte or give up
				bit_cnt    <= 4'h0;
				sda_oe_n_o <= 1'b1;
				case (state)
					ST_SEL: begin
						if (sda_oe_n_o) begin
							state <= ST_IDLE;
						end else if (shreg[`EEPRW_SEL_RW_BIT]) begin
							state      <= ST_RDAT;
							shreg      <= rd_byte;
							sda_oe_n_o <= rd_byte[7];
						end else begin
							state <= ST_AHI;
						end
					end
					ST_AHI: state <= ST_ALO;
					ST_ALO: state <= ST_WDAT;
					ST_WDAT: state <= ST_WDAT;
					ST_RDAT: begin
						if (mack) begin
							shreg      <= rd_byte;
							sda_oe_n_o <= rd_byte[7];
						end else begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end else if (state == ST_RDAT && bit_cnt != 4'h0) begin
				// shift out the next bit on each falling clock
				shreg      <= {shreg[6:0], 1'b1};
				sda_oe_n_o <= shreg[6];
			end
		end
	end
endmodule // eeprw_core
`default_nettype wire

// file: hdl/eeprw_map.vh
// eeprw_map.vh: constants shared by the two-wire EEPROM read and write-poll slave
// assumes inclusion by bare name from files under hdl/
`ifndef EEPRW_MAP_VH
`define EEPRW_MAP_VH

// device select code layout
`define EEPRW_DEVTYPE_MEM   4'hA
`define EEPRW_DEVTYPE_FEAT  4'hB
`define EEPRW_SEL_CE_BIT    3
`define EEPRW_SEL_RW_BIT    0

// configurable device address register
`define EEPRW_CDA_ADDR      8'h80
`define EEPRW_CDA_C2_BIT    1
`define EEPRW_CDA_RESET     8'h00
`define EEPRW_FEAT_IDLE     8'hFF

// array and buffer shape
`define EEPRW_ADDR_BITS     18
`define EEPRW_FIFO_DEPTH    16

// internal write cycle time, derived as a count of clock cycles
`define EEPRW_TW_US         4000
`define EEPRW_CLK_MHZ       50
`define EEPRW_TW_CYCLES     (`EEPRW_TW_US * `EEPRW_CLK_MHZ)

`endif

// file: hdl/eeprw_fifo.v
// eeprw_fifo.v: synchronous FIFO with valid/ready on both sides and a flush input
// assumes one clock domain; flush drops every stored word in one cycle
`timescale 1ns/1ns
`default_nettype none
module eeprw_fifo #(
	parameter W     = 26,
	parameter DEPTH = 16
) (
	// clock and reset
	input  wire          clock_i,
	input  wire          rst_i,
	input  wire          clr_i,
	// fill side
	input  wire          in_valid_i,
	output wire          in_ready_o,
	input  wire [W-1:0]  in_data_i,
	// drain side
	output wire          out_valid_o,
	input  wire          out_ready_i,
	output wire [W-1:0]  out_data_o
);
	localparam PW = $clog2(DEPTH);

	reg [W-1:0] store [0:DEPTH-1];
	reg [PW:0]  wr_ptr;
	reg [PW:0]  rd_ptr;
	wire        push;
	wire        pop;

	// one extra pointer bit tells full from empty
	assign in_ready_o  = (wr_ptr - rd_ptr) != DEPTH[PW:0];
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o  = store[rd_ptr[PW-1:0]];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage is not reset; only the pointers carry state
	always @(posedge clock_i) begin
		if (push)
			store[wr_ptr[PW-1:0]] <= in_data_i;
	end

	// pointer update, flush wins over traffic
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= {(PW+1){1'b0}};
			rd_ptr <= {(PW+1){1'b0}};
		end else if (clr_i) begin
			wr_ptr <= {(PW+1){1'b0}};
			rd_ptr <= {(PW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + {{PW{1'b0}}, 1'b1};
			if (pop)
				rd_ptr <= rd_ptr + {{PW{1'b0}}, 1'b1};
		end
	end
endmodule // eeprw_fifo
`default_nettype wire

// file: hdl/eeprw_ecc.v
// eeprw_ecc.v: single-error-correcting code over one four-byte group
// assumes 32 data bits and 6 check bits in a 38-position code word
`timescale 1ns/1ns
`default_nettype none
module eeprw_ecc (
	// encode side
	input  wire [31:0] wdat_i,
	output reg  [5:0]  wchk_o,
	// decode side
	input  wire [31:0] rdat_i,
	input  wire [5:0]  rchk_i,
	output reg  [31:0] rcor_o
);
	integer   d;
	integer   i;
	reg [5:0] pd;
	reg [5:0] syn;

	// code word position of data bit k; powers of two hold check bits
	function [5:0] dpos;
		input integer k;
		integer p;
		integer n;
		begin
			dpos = 6'h00;
			n = 0;
			for (p = 3; p < 39; p = p + 1) begin
				if ((p & (p - 1)) != 0) begin
					if (n == k)
						dpos = p[5:0];
					n = n + 1;
				end
			end
		end
	endfunction

	// check bits and syndrome; a syndrome on a check position leaves data alone
	always @* begin
		wchk_o = 6'h00;
		syn    = rchk_i;
		rcor_o = rdat_i;
		pd     = 6'h00;
		for (d = 0; d < 32; d = d + 1) begin
			pd = dpos(d);
			for (i = 0; i < 6; i = i + 1) begin
				if (pd[i]) begin
					wchk_o[i] = wchk_o[i] ^ wdat_i[d];
					syn[i]    = syn[i] ^ rdat_i[d];
				end
			end
		end
		for (d = 0; d < 32; d = d + 1) begin
			if (syn == dpos(d))
				rcor_o[d] = ~rdat_i[d];
		end
	end
endmodule // eeprw_ecc
`default_nettype wire

// file: dv/eeprw_checker.sv
// eeprw_checker.sv: timing checks on the slave's pins and busy flag
// assumes binding to eeprw_core; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module eeprw_checker #(
	parameter int TW_CYCLES = 200000
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// bus pins and status
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic busy_o
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] since_stop;
	int         busy_len;
	wire logic  start_ev;
	wire logic  stop_ev;

	// pin-level start and stop, seen one clock after the pin moves
	assign start_ev = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_ev = scl_i & scl_q & ~sda_q & sda_i;

	// age of the last stop saturates so it never wraps back to small
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			since_stop <= 4'hF;
			busy_len <= 0;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
			since_stop <= stop_ev ? 4'h0 : (since_stop == 4'hF ? 4'hF : since_stop + 4'h1);
			busy_len <= busy_o ? busy_len + 1 : 0;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	chk_busy_quiet: assert property (busy_o |-> sda_oe_n_o)
		else $error("bus driven during write cycle");
	chk_poll_keeps: assert property ((busy_o && start_ev && busy_len < TW_CYCLES - 2) |=> busy_o)
		else $error("poll cut the write cycle short");
	chk_hold_busy: assert property ($rose(busy_o) |=> busy_o [*8])
		else $error("write cycle dropped early");
	chk_busy_length: assert property ($fell(busy_o) |-> busy_len >= TW_CYCLES)
		else $error("write cycle shorter than its count");
	chk_busy_from_stop: assert property ($rose(busy_o) |-> since_stop <= 4'h6)
		else $error("write cycle began without a stop");
	chk_bit_stable: assert property ((scl_i && $past(scl_i) && $past(scl_i, 2)) |-> $stable(sda_oe_n_o))
		else $error("data moved while clock high");
	chk_stop_idle: assert property (stop_ev |=> sda_oe_n_o [*4])
		else $error("bus held after stop");
	chk_level_zero: assert property (sda_o == 1'b0)
		else $error("drive level not low");

	cover property ($rose(busy_o));
	cover property (busy_o && start_ev);
	cover property (stop_ev && !busy_o);
endmodule // eeprw_checker

bind eeprw_core eeprw_checker #(.TW_CYCLES(TW_CYCLES)) u_chk (.clock_i(clock_i), .rst_i(rst_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
`default_nettype wire

// file: dv/eeprw_ctrl_model.sv
// eeprw_ctrl_model.sv: behavioural two-wire bus controller
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/1ns
`default_nettype none
module eeprw_ctrl_model (
	// clock and bus
	input  wire logic clock_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// steps off the edge so the design never races the controller
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// 4 clocks low then 4 high: a 160 ns bit
	task automatic bit_slot(input logic b, output logic s);
		sda_o = b;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		s = sda_i;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask
	task automatic start();
		sda_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b1;
		tick(4);
	endtask
	task automatic send(input logic [7:0] b, inout logic ok);
		logic s;
		for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
		bit_slot(1'b1, s);
		ok = ok & ~s;
	endtask
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
		bit_slot(~ack, s);
	endtask
	// stop straight after the last data acknowledge starts the write cycle
	task automatic write(input logic [7:0] sel, input logic [15:0] a, input int n,
		input logic [7:0] w [4], output logic ok);
		ok = 1'b1;
		start();
		send(sel, ok);
		send(a[15:8], ok);
		send(a[7:0], ok);
		for (int i = 0; i < n; i++) send(w[i], ok);
		stop();
	endtask
	// start plus select again on each refusal
	task automatic poll(input logic [7:0] sel, output int n);
		logic a;
		n = 0;
		a = 1'b0;
		while (!a && n < 400) begin
			a = 1'b1;
			start();
			send(sel, a);
			n++;
		end
	endtask
	// dummy write loads the counter, then repeated start with the same upper bits
	task automatic read(input logic [7:0] sel, input logic ld, input logic [15:0] a,
		input int n, output logic ok, output logic [7:0] d [4]);
		ok = 1'b1;
		start();
		if (ld) begin
			send(sel, ok);
			send(a[15:8], ok);
			send(a[7:0], ok);
			start();
		end
		send(sel | 8'h01, ok);
		for (int i = 0; i < n; i++) get_byte(i < n - 1, d[i]);
		stop();
	endtask
endmodule // eeprw_ctrl_model
`default_nettype wire

// file: dv/eeprom_read_and_write_poll_bench.sv
// eeprom_read_and_write_poll_bench.sv: self-checking bench for eeprw_core
// assumes the controller model and a pull-up on the wired sda line
`timescale 1ns/1ns
`default_nettype none
module eeprom_read_and_write_poll_bench;
	logic      clock_i;
	logic      rst_i;
	wire logic scl;
	wire logic sda_m;
	wire logic sda_w;
	wire logic sda_o;
	wire logic sda_oe_n_o;
	wire logic busy_o;
	int        num_errors;
	int        tests_run;
	int        cycles;

	// wired-AND of controller and device, pulled up when both release
	assign sda_w = sda_m & (sda_oe_n_o | sda_o);

	eeprw_core #(.TW_CYCLES(400)) dut (.clock_i(clock_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o));
	eeprw_ctrl_model bm (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));

	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic wrap_up();
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// write, then poll through the write cycle until acknowledged
	task automatic wr(input logic [7:0] sel, input logic [7:0] psel, input logic [15:0] a,
		input int n, input logic [7:0] w [4]);
		logic ok;
		int   np;
		bm.write(sel, a, n, w, ok);
		check({7'h00, ok}, 8'h01);
		check({7'h00, busy_o}, 8'h01);
		bm.poll(psel, np);
		check({7'h00, np > 1}, 8'h01);
		check({7'h00, busy_o}, 8'h00);
		bm.stop();
	endtask
	task automatic rd(input logic [7:0] sel, input logic ld, input logic [15:0] a, input int n,
		input logic [7:0] e [4]);
		logic       ok;
		logic [7:0] d [4];
		bm.read(sel, ld, a, n, ok, d);
		check({7'h00, ok}, 8'h01);
		for (int i = 0; i < n; i++) check(d[i], e[i]);
	endtask

	task automatic t_write_poll();
		wr(8'hA0, 8'hA0, 16'h0000, 4, '{8'h11, 8'h22, 8'h33, 8'h44});
		wr(8'hA6, 8'hA6, 16'hFFFE, 2, '{8'hAA, 8'hBB, 8'h00, 8'h00});
		wr(8'hA0, 8'hA0, 16'h0001, 1, '{8'h55, 8'h00, 8'h00, 8'h00});
	endtask
	// stops after the address bytes, or one slot late after a data byte, start no write
	task automatic t_stop_early();
		logic ok;
		logic s;
		ok = 1'b1;
		bm.start();
		bm.send(8'hA0, ok);
		bm.send(8'h00, ok);
		bm.send(8'h02, ok);
		bm.stop();
		bm.tick(6);
		check({7'h00, busy_o}, 8'h00);
		// byte 8'h77 for address 2 is buffered, then the stop lands in slot eleven
		bm.start();
		bm.send(8'hA0, ok);
		bm.send(8'h00, ok);
		bm.send(8'h02, ok);
		bm.send(8'h77, ok);
		bm.bit_slot(1'b0, s);
		bm.stop();
		bm.tick(6);
		check({7'h00, ok}, 8'h01);
		check({7'h00, busy_o}, 8'h00);
	endtask
	// roll-over past the top, group neighbours intact, then a repaired current read
	task automatic t_reads();
		rd(8'hA6, 1'b1, 16'hFFFE, 4, '{8'hAA, 8'hBB, 8'h11, 8'h55});
		// one flipped bit in byte two of group zero must be read back corrected
		dut.mem[0][17] = ~dut.mem[0][17];
		rd(8'hA0, 1'b0, 16'h0000, 1, '{8'h33, 8'h00, 8'h00, 8'h00});
	endtask
	// a feature read loads the shared counter
	task automatic t_feature();
		rd(8'hB0, 1'b1, 16'h0003, 1, '{8'hFF, 8'h00, 8'h00, 8'h00});
		rd(8'hA0, 1'b0, 16'h0000, 1, '{8'h44, 8'h00, 8'h00, 8'h00});
	endtask
	// new chip-enable value: only matching select codes acknowledged
	task automatic t_chip_enable();
		logic ok;
		wr(8'hB0, 8'hA8, 16'h0080, 1, '{8'h02, 8'h00, 8'h00, 8'h00});
		ok = 1'b1;
		bm.start();
		bm.send(8'hA0, ok);
		bm.stop();
		check({7'h00, ok}, 8'h00);
		rd(8'hA8, 1'b1, 16'h0000, 1, '{8'h11, 8'h00, 8'h00, 8'h00});
	endtask

	// ceiling well above the roughly 5800 cycles the tests need
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	initial begin
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		rst_i = 1'b1;
		repeat (6) @(posedge clock_i);
		#1;
		rst_i = 1'b0;
		bm.tick(4);
		t_write_poll();
		t_stop_early();
		t_reads();
		t_feature();
		t_chip_enable();
		wrap_up();
	end
endmodule // eeprom_read_and_write_poll_bench
`default_nettype wire
